//--- shared/cbi_pkg.sv
// Purpose: constants and state types for the CPU bus interface flow block
// Assumes: one clock, synchronous active-low reset
// Notes: register offsets are byte addresses on AXI4-Lite
// How it works
// - Capture CPU bus items every rising edge
// - Sixteen-entry item buffer, registered pins, two stages
// - Empty buffer lets reads load row directly
// - Idle interface lets reads skip stage too
// - One read outstanding; read-ready tied asserted (low)
// - Drive read data with response-valid low
// - L2 enable negated, third word held back
// - Writes go buffer, row, then target
// - Always keep buffer room for one read
// - Negate write-ready at six buffered items
// - Stalled single write: one-clock ready below 13
// - Stalled block write: one-clock ready below 10
// - At five items keep write-ready asserted
// - Read stall: write-ready back at five
// - Even parity check/generate on data only
// - Check at row, generate at drive
// - Parity error raises interrupt when enabled
// - Bad block word: command bit 5, bad parity
// - L2 hit two clocks later aborts block read
// - Unmatched read answered with zeros, chosen parity
// - Unmatched read raises interrupt when enabled
// - Multi-controller: zeros only after time-out
package cbi_pkg;
   localparam int          DEPTH      = 16;
   localparam int          ITEM_W     = 81;
   localparam int          CMD_LSB    = 72;
   localparam int          CHK_LSB    = 64;
   localparam logic [4:0]  LOW_MARK   = 5'd5;
   localparam logic [4:0]  NB_MARK    = 5'd13;
   localparam logic [4:0]  BLK_MARK   = 5'd10;
   localparam logic [1:0]  HOLD_BEAT  = 2'd2;
   localparam logic [1:0]  LAST_BEAT  = 2'd3;
   localparam int          CMD_DATA   = 8;
   localparam int          CMD_WR     = 7;
   localparam int          CMD_BLK    = 6;
   localparam int          CMD_ERR    = 5;
   localparam logic [3:0]  REG_CTRL   = 4'h0;
   localparam logic [3:0]  REG_TOUT   = 4'h4;
   localparam logic [3:0]  REG_STAT   = 4'h8;
   localparam int          C_PDIS     = 0;
   localparam int          C_CPDIS    = 1;
   localparam int          C_PEIE     = 2;
   localparam int          C_NTIE     = 3;
   localparam int          C_MULTI    = 4;
   localparam int          C_BADPAR   = 5;
   localparam logic [5:0]  CTRL_RST   = 6'h00;
   localparam logic [31:0] TOUT_RST   = 32'h0000_0100;
   localparam logic [1:0]  RESP_OK    = 2'h0;
   localparam logic [1:0]  RESP_ERR   = 2'h2;

   typedef logic [ITEM_W-1:0] cbi_item_t;

   typedef struct packed {
      cbi_item_t [DEPTH-1:0] fifo;
      logic [3:0]  wp;
      logic [3:0]  rp;
      logic [4:0]  cnt;
      logic        stgV;
      cbi_item_t   stg;
      logic        rowV;
      cbi_item_t   row;
      logic        readPend;
      logic        readBlk;
      logic        readIssued;
      logic [1:0]  hitPipe;
      logic        wrRdyN;
      logic        stallPend;
      logic        stallBlk;
      logic        rspVN;
      logic        adOeN;
      logic [63:0] adOut;
      logic [8:0]  cmdOut;
      logic [7:0]  chkOut;
      logic        doeN;
      logic [1:0]  beat;
      logic        holdV;
      logic        lastPend;
      logic [64:0] hold;
      logic        toRun;
      logic [31:0] toCnt;
      logic        tgtAbort;
      logic        irqPar;
      logic        irqNt;
      logic        awHave;
      logic [3:0]  awAddr;
      logic        wHave;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [5:0]  ctrl;
      logic [31:0] tout;
   } cbi_state_t;
endpackage

//--- core/cbi_bridge.sv
// Purpose: CPU bus interface: buffer, flow control, read return, parity
// Assumes: CPU pins synchronous to core_clk
// Notes: target side is one item per accept
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cbi_bridge
   import cbi_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        cpuValidN,
   input  wire logic [63:0] cpuAdIn,
   input  wire logic [8:0]  cpuCmdIn,
   input  wire logic [7:0]  cpuChkIn,
   output logic [63:0]      cpuAdOut,
   output logic [8:0]       cpuCmdOut,
   output logic [7:0]       cpuChkOut,
   output logic             cpuAdOeN,
   output logic             response_valid_n,
   output logic             write_ready_n,
   output logic             l2_data_output_enable_n,
   input  wire logic        l2_hit,
   output logic             tgtReqValid,
   output logic [80:0]      tgtReqItem,
   input  wire logic        tgtAccept,
   output logic             tgtAbort,
   input  wire logic        tgtRspValid,
   input  wire logic [63:0] tgtRspData,
   input  wire logic        tgtRspErr,
   input  wire logic        tgtNoMatch,
   output logic             irqParity,
   output logic             irqNoTarget,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   cbi_state_t s_reg;
   cbi_state_t s_next;

   function automatic logic [7:0] evenPar(input logic [63:0] d);
      logic [7:0] p;
      for (int i = 0; i < 8; i++) begin
         p[i] = ^d[8*i +: 8];
      end
      return p;
   endfunction

   function automatic logic isRead(input cbi_item_t it);
      return !it[CMD_LSB+CMD_DATA] && !it[CMD_LSB+CMD_WR];
   endfunction

   function automatic logic isWrAddr(input cbi_item_t it);
      return !it[CMD_LSB+CMD_DATA] && it[CMD_LSB+CMD_WR];
   endfunction

   logic      parOn;
   logic      pinV;
   cbi_item_t pinItem;
   logic      realRsp;
   logic      zeroRsp;
   logic      popRow;
   logic      bypStg;
   logic      bypPin;
   logic      killRd;

   always_comb begin
      s_next = s_reg;
      parOn = !s_reg.ctrl[C_PDIS] && !s_reg.ctrl[C_CPDIS];
      pinV = !cpuValidN;
      pinItem = {cpuCmdIn, cpuChkIn, cpuAdIn};
      realRsp = tgtRspValid && !tgtNoMatch;
      zeroRsp = 1'b0;
      s_next.tgtAbort = 1'b0;
      s_next.irqPar = 1'b0;
      s_next.irqNt = 1'b0;
      s_next.rspVN = 1'b1;
      s_next.adOeN = 1'b1;

      // Row drain and refill
      popRow = s_reg.rowV && tgtAccept;
      if (popRow) begin
         s_next.rowV = 1'b0;
         if (isRead(s_reg.row)) begin
            s_next.readIssued = 1'b1;
         end
         if (s_reg.row[CMD_LSB+CMD_DATA] && parOn
             && s_reg.row[CHK_LSB +: 8] != evenPar(s_reg.row[63:0])) begin
            s_next.irqPar = s_reg.ctrl[C_PEIE];
         end
      end
      bypStg = 1'b0;
      bypPin = 1'b0;
      if (!s_reg.rowV || popRow) begin
         if (s_reg.cnt != 5'd0) begin
            s_next.row = s_reg.fifo[s_reg.rp];
            s_next.rowV = 1'b1;
            s_next.rp = s_reg.rp + 4'd1;
            s_next.cnt = s_reg.cnt - 5'd1;
         end else if (s_reg.stgV && isRead(s_reg.stg)) begin
            bypStg = 1'b1;
            s_next.row = s_reg.stg;
            s_next.rowV = 1'b1;
         end else if (!s_reg.stgV && !s_reg.rowV && pinV && isRead(pinItem)) begin
            bypPin = 1'b1;
            s_next.row = pinItem;
            s_next.rowV = 1'b1;
         end
      end

      // Stage into buffer, pins into stage
      if (s_reg.stgV && !bypStg) begin
         s_next.fifo[s_reg.wp] = s_reg.stg;
         s_next.wp = s_reg.wp + 4'd1;
         s_next.cnt = s_next.cnt + 5'd1;
      end
      s_next.stgV = pinV && !bypPin;
      s_next.stg = pinItem;
      if (pinV && isRead(pinItem)) begin
         s_next.readPend = 1'b1;
         s_next.readBlk = pinItem[CMD_LSB+CMD_BLK];
         s_next.readIssued = bypPin;
         s_next.beat = 2'd0;
      end
      if (pinV && isWrAddr(pinItem)) begin
         s_next.stallBlk = pinItem[CMD_LSB+CMD_BLK];
      end

      // L2 hit check two clocks after a block read address
      s_next.hitPipe = {s_reg.hitPipe[0], pinV && isRead(pinItem) && pinItem[CMD_LSB+CMD_BLK]};
      killRd = s_reg.hitPipe[1] && l2_hit;
      if (killRd) begin
         s_next.readPend = 1'b0;
         s_next.tgtAbort = s_reg.readIssued || (popRow && isRead(s_reg.row));
         s_next.readIssued = 1'b0;
         if (s_next.rowV && isRead(s_next.row)) begin
            s_next.rowV = 1'b0;
         end
         if (s_next.stgV && isRead(s_next.stg)) begin
            s_next.stgV = 1'b0;
         end
         if (s_next.cnt != 5'd0 && isRead(s_next.fifo[s_next.wp - 4'd1])) begin
            s_next.wp = s_next.wp - 4'd1;
            s_next.cnt = s_next.cnt - 5'd1;
         end
      end else if (s_reg.hitPipe[1] && s_reg.readPend) begin
         s_next.doeN = 1'b1;
      end

      // Write-ready flow control
      if (s_next.cnt <= LOW_MARK) begin
         s_next.wrRdyN = 1'b0;
         s_next.stallPend = 1'b1;
      end else if (s_reg.stallPend && s_reg.wrRdyN
                   && s_next.cnt < (s_reg.stallBlk ? BLK_MARK : NB_MARK)) begin
         s_next.wrRdyN = 1'b0;
         s_next.stallPend = 1'b0;
      end else begin
         s_next.wrRdyN = 1'b1;
      end

      // Unmatched read and time-out
      if (s_reg.readPend && tgtRspValid && tgtNoMatch) begin
         if (s_reg.ctrl[C_MULTI]) begin
            s_next.toRun = 1'b1;
            s_next.toCnt = s_reg.tout;
         end else begin
            zeroRsp = 1'b1;
         end
      end
      if (s_reg.toRun) begin
         s_next.toCnt = s_reg.toCnt - 32'd1;
         if (realRsp) begin
            s_next.toRun = 1'b0;
         end else if (s_reg.toCnt <= 32'd1) begin
            s_next.toRun = 1'b0;
            zeroRsp = 1'b1;
         end
      end

      // Read data return
      if (zeroRsp) begin
         s_next.adOut = 64'h0;
         s_next.cmdOut = 9'h100;
         s_next.chkOut = s_reg.ctrl[C_BADPAR] ? 8'hFF : 8'h00;
         s_next.rspVN = 1'b0;
         s_next.adOeN = 1'b0;
         s_next.readPend = 1'b0;
         s_next.irqNt = s_reg.ctrl[C_NTIE];
      end else if (s_reg.lastPend) begin
         s_next.adOut = s_reg.hold[63:0];
         s_next.cmdOut = {3'b100, s_reg.hold[64], 5'h0};
         s_next.chkOut = parOn ? evenPar(s_reg.hold[63:0]) ^ {8{s_reg.hold[64]}} : 8'h00;
         s_next.rspVN = 1'b0;
         s_next.adOeN = 1'b0;
         s_next.lastPend = 1'b0;
         s_next.holdV = 1'b0;
         s_next.readPend = 1'b0;
      end else if (realRsp && s_reg.readPend) begin
         s_next.beat = s_reg.beat + 2'd1;
         if (s_reg.readBlk && s_reg.beat == HOLD_BEAT) begin
            s_next.holdV = 1'b1;
            s_next.hold = {tgtRspErr, tgtRspData};
         end else begin
            s_next.adOut = (s_reg.holdV ? s_reg.hold[63:0] : tgtRspData);
            s_next.cmdOut = {3'b100, (s_reg.holdV ? s_reg.hold[64] : tgtRspErr), 5'h0};
            s_next.chkOut = parOn ? evenPar(s_next.adOut) ^ {8{s_next.cmdOut[CMD_ERR]}} : 8'h00;
            s_next.rspVN = 1'b0;
            s_next.adOeN = 1'b0;
            if (s_reg.readBlk && s_reg.beat == LAST_BEAT) begin
               s_next.doeN = 1'b0;
               s_next.hold = {tgtRspErr, tgtRspData};
               s_next.lastPend = 1'b1;
            end else if (!s_reg.readBlk) begin
               s_next.readPend = 1'b0;
            end
         end
      end
      if (!s_next.readPend) begin
         s_next.readIssued = 1'b0;
      end

      // AXI4-Lite register slave
      if (s_reg.awready && s_axi_awvalid) begin
         s_next.awHave = 1'b1;
         s_next.awAddr = s_axi_awaddr;
      end
      if (s_reg.wready && s_axi_wvalid) begin
         s_next.wHave = 1'b1;
         s_next.wData = s_axi_wdata;
         s_next.wStrb = s_axi_wstrb;
      end
      if (s_reg.awHave && s_reg.wHave && !s_reg.bvalid) begin
         s_next.awHave = 1'b0;
         s_next.wHave = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = RESP_OK;
         unique case (s_reg.awAddr)
            REG_CTRL: begin
               if (s_reg.wStrb[0]) begin
                  s_next.ctrl = s_reg.wData[5:0];
               end
            end
            REG_TOUT: begin
               for (int b = 0; b < 4; b++) begin
                  if (s_reg.wStrb[b]) begin
                     s_next.tout[8*b +: 8] = s_reg.wData[8*b +: 8];
                  end
               end
            end
            REG_STAT: s_next.bresp = RESP_OK;
            default: s_next.bresp = RESP_ERR;
         endcase
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      s_next.awready = !s_next.awHave && !s_next.bvalid;
      s_next.wready = !s_next.wHave && !s_next.bvalid;
      if (s_reg.arready && s_axi_arvalid) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = RESP_OK;
         unique case (s_axi_araddr)
            REG_CTRL: s_next.rdata = {26'h0, s_reg.ctrl};
            REG_TOUT: s_next.rdata = s_reg.tout;
            REG_STAT: s_next.rdata = {22'h0, s_reg.wrRdyN, s_reg.readPend, s_reg.rowV, s_reg.stgV, 1'b0, s_reg.cnt};
            default: begin
               s_next.rdata = 32'h0;
               s_next.rresp = RESP_ERR;
            end
         endcase
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      s_next.arready = !s_next.rvalid;
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_reg <= '0;
         s_reg.rspVN <= 1'b1;
         s_reg.adOeN <= 1'b1;
         s_reg.stallPend <= 1'b1;
         s_reg.ctrl <= CTRL_RST;
         s_reg.tout <= TOUT_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cpuAdOut = s_reg.adOut;
   assign cpuCmdOut = s_reg.cmdOut;
   assign cpuChkOut = s_reg.chkOut;
   assign cpuAdOeN = s_reg.adOeN;
   assign response_valid_n = s_reg.rspVN;
   assign write_ready_n = s_reg.wrRdyN;
   assign l2_data_output_enable_n = s_reg.doeN;
   assign tgtReqValid = s_reg.rowV;
   assign tgtReqItem = s_reg.row;
   assign tgtAbort = s_reg.tgtAbort;
   assign irqParity = s_reg.irqPar;
   assign irqNoTarget = s_reg.irqNt;
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_fifo_bound: assert property (s_reg.cnt <= 5'd16)
      else $error("buffer occupancy above depth");
   a_ready_low: assert property (s_reg.cnt < LOW_MARK |=> !write_ready_n)
      else $error("write-ready not asserted at low occupancy");
   a_ready_high: assert property (s_reg.cnt >= BLK_MARK + 5'd3 |=> write_ready_n)
      else $error("write-ready asserted while buffer nearly full");
   a_pulse_once: assert property (s_reg.cnt > LOW_MARK + 5'd1 && $fell(write_ready_n) |=> write_ready_n)
      else $error("stall release lasted more than one clock");
   a_rsp_drive: assert property (!response_valid_n |-> !cpuAdOeN)
      else $error("response valid without driving bus");
   a_rsp_parity: assert property (!response_valid_n && parOn && !cpuCmdOut[CMD_ERR]
                                  |-> cpuChkOut == evenPar(cpuAdOut) || cpuAdOut == 64'h0)
      else $error("generated parity not even");
   a_bad_word: assert property (!response_valid_n && parOn && cpuCmdOut[CMD_ERR]
                                |-> cpuChkOut == ~evenPar(cpuAdOut))
      else $error("bad word without forced bad parity");
   a_hit_abort: assert property (s_reg.hitPipe[1] && l2_hit |=> !s_reg.readPend)
      else $error("read survives an L2 hit");
   a_zero_rsp: assert property (tgtRspValid && tgtNoMatch && s_reg.readPend && !s_reg.ctrl[C_MULTI]
                                |=> !response_valid_n && cpuAdOut == 64'h0)
      else $error("unmatched read not answered with zeros");
   a_doe_last: assert property ($fell(l2_data_output_enable_n) && s_reg.lastPend
                                |=> !response_valid_n)
      else $error("last word not driven after enable returns");

   c_block_read: cover property (s_reg.lastPend ##1 !response_valid_n);
   c_stall: cover property ($rose(write_ready_n) ##[1:40] $fell(write_ready_n));
   c_timeout: cover property (s_reg.toRun ##[1:300] !response_valid_n);
endmodule

//--- tb/cbi_cpu_model.sv
// Purpose: processor-side driver for the CPU bus interface block
// Assumes: items change just after a rising core_clk edge
// Notes: bus shows the inverted last value while released
`timescale 1ns/1ps
module cbi_cpu_model (
   input  wire logic        core_clk,
   output logic             cpuValidN,
   output logic [63:0]      cpuAdIn,
   output logic [8:0]       cpuCmdIn,
   output logic [7:0]       cpuChkIn,
   output logic             readReadyN
);
   assign readReadyN = 1'b0;
   initial begin
      cpuValidN = 1'b1;
      cpuAdIn   = 64'h0;
      cpuCmdIn  = 9'h0;
      cpuChkIn  = 8'h0;
   end
   // One item for one cycle
   task automatic put(input logic [8:0] c, input logic [63:0] a, input logic [7:0] k);
      @(posedge core_clk);
      cpuValidN <= 1'b0;
      cpuAdIn   <= a;
      cpuCmdIn  <= c;
      cpuChkIn  <= k;
   endtask
   // Release with a changed pattern
   task automatic rel();
      @(posedge core_clk);
      cpuValidN <= 1'b1;
      cpuAdIn   <= ~cpuAdIn;
      cpuCmdIn  <= ~cpuCmdIn;
      cpuChkIn  <= ~cpuChkIn;
   endtask
endmodule

//--- tb/tb.sv
// Purpose: self-checking bench for the CPU bus interface block
// Assumes: target side answered by this bench, one read at a time
// Notes: read data checked as queued response words
`timescale 1ns/1ps
module tb;
   import cbi_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic cpuValidN, readReadyN;
   logic [63:0] cpuAdIn, cpuAdOut, d64;
   logic [8:0] cpuCmdIn, cpuCmdOut;
   logic [7:0] cpuChkIn, cpuChkOut;
   logic cpuAdOeN, response_valid_n, write_ready_n, l2_data_output_enable_n, tgtReqValid, tgtAbort;
   logic irqParity, irqNoTarget, sawDoe;
   logic l2_hit = 1'b0, tgtAccept = 1'b1, tgtRspValid = 1'b0, tgtRspErr = 1'b0, tgtNoMatch = 1'b0;
   logic [63:0] tgtRspData = 64'h0;
   logic [80:0] tgtReqItem;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [80:0] rsp[$], tq[$];
   realtime rspT[$];
   int err_count = 0, comparisons = 0, cyc = 0, nPar = 0, nNt = 0, nAbort = 0;

   cbi_cpu_model cpu (.core_clk, .cpuValidN, .cpuAdIn, .cpuCmdIn, .cpuChkIn, .readReadyN);
   cbi_bridge DUT (
      .core_clk, .nrst, .cpuValidN, .cpuAdIn, .cpuCmdIn, .cpuChkIn, .cpuAdOut, .cpuCmdOut, .cpuChkOut,
      .cpuAdOeN, .response_valid_n, .write_ready_n, .l2_data_output_enable_n, .l2_hit, .tgtReqValid,
      .tgtReqItem, .tgtAccept, .tgtAbort, .tgtRspValid, .tgtRspData, .tgtRspErr, .tgtNoMatch, .irqParity,
      .irqNoTarget, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #4 core_clk = ~core_clk;

   task automatic end_sim();
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [80:0] s, input logic [80:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("Error t=%0t seen=%h expected=%h", $time, s, e);
      end
   endtask

   // Watchdog and port monitor
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
      if (response_valid_n === 1'b0) begin
         rsp.push_back({cpuCmdOut, cpuChkOut, cpuAdOut});
         rspT.push_back($realtime);
         chk(cpuAdOeN, 1'b0);
      end
      if (tgtReqValid === 1'b1 && tgtAccept === 1'b1)
         tq.push_back(tgtReqItem);
      if (irqParity === 1'b1)
         nPar++;
      if (irqNoTarget === 1'b1)
         nNt++;
      if (tgtAbort === 1'b1)
         nAbort++;
      if (l2_data_output_enable_n === 1'b1)
         sawDoe = 1'b1;
   end

   function automatic logic [7:0] par(input logic [63:0] d);
      for (int i = 0; i < 8; i++)
         par[i] = ^d[8*i +: 8];
   endfunction

   function automatic logic [63:0] itm(input int k);
      return {32'hA5A5_0000, 32'(k)};
   endfunction

   task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw = 1'b1;
      logic w = 1'b1;
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (aw || w) begin
         @(posedge core_clk);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready  <= 1'b1;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic give(input logic [63:0] d, input logic e, input logic nm);
      @(posedge core_clk);
      tgtRspValid <= 1'b1;
      tgtRspData  <= d;
      tgtRspErr   <= e;
      tgtNoMatch  <= nm;
      @(posedge core_clk);
      tgtRspValid <= 1'b0;
      tgtRspData  <= ~d;
      tgtRspErr   <= 1'b0;
      tgtNoMatch  <= 1'b0;
   endtask

   task automatic wrsp(input int n);
      do @(posedge core_clk); while (rsp.size() < n);
      repeat (4) @(posedge core_clk);
   endtask

   // One read outstanding at a time
   task automatic rdq(input logic [8:0] c, input logic [63:0] a);
      tq.delete();
      rsp.delete();
      rspT.delete();
      cpu.put(c, a, 8'h00);
      cpu.rel();
      @(posedge core_clk);
      chk(tgtReqValid, 1'b1);
      do @(posedge core_clk); while (tq.size() == 0);
      chk(tq[0], {c, 8'h00, a});
   endtask

   task automatic badwr();
      cpu.put(9'h080, 64'h6000, 8'h00);
      cpu.put(9'h180, 64'h0F, 8'h01);
      cpu.rel();
      repeat (10) @(posedge core_clk);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      realtime t4;
      int n;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk({write_ready_n, response_valid_n, cpuAdOeN, l2_data_output_enable_n, tgtReqValid}, 5'b01100);
      chk(readReadyN, 1'b0);
      axr(REG_CTRL, d, r);
      chk({r, d}, {RESP_OK, 26'h0, CTRL_RST});
      axr(REG_TOUT, d, r);
      chk({r, d}, {RESP_OK, TOUT_RST});
      axr(4'hC, d, r);
      chk({r, d}, {RESP_ERR, 32'h0});
      axw(4'hC, 32'h1, r);
      chk(r, RESP_ERR);
      // Single read from idle
      rdq(9'h000, 64'h1000);
      give(64'h0123_4567_89AB_CDEF, 1'b0, 1'b0);
      wrsp(1);
      chk(rsp[0], {9'h100, par(64'h0123_4567_89AB_CDEF), 64'h0123_4567_89AB_CDEF});
      // Block read miss, bad second word, late last word
      sawDoe = 1'b0;
      rdq(9'h040, 64'h3000);
      give(64'h11, 1'b0, 1'b0);
      give(64'h22, 1'b1, 1'b0);
      give(64'h33, 1'b0, 1'b0);
      repeat (4) @(posedge core_clk);
      t4 = $realtime;
      give(64'h44, 1'b0, 1'b0);
      wrsp(4);
      for (int i = 0; i < 4; i++) begin
         d64 = 64'h11 * (i + 1);
         chk(rsp[i][63:0], d64);
         chk(rsp[i][80:72], (i == 1) ? 9'h120 : 9'h100);
         chk(rsp[i][71:64] !== par(d64), i == 1);
      end
      chk(rspT[2] > t4, 1'b1);
      chk({sawDoe, l2_data_output_enable_n}, 2'b10);
      // Secondary cache hit aborts block read
      tq.delete();
      rsp.delete();
      nAbort = 0;
      cpu.put(9'h040, 64'h4000, 8'h00);
      cpu.rel();
      @(posedge core_clk);
      l2_hit <= 1'b1;
      @(posedge core_clk);
      l2_hit <= 1'b0;
      repeat (10) @(posedge core_clk);
      chk(nAbort, 1);
      chk(rsp.size(), 0);
      // Writes stall against a blocked target, then a read
      tgtAccept <= 1'b0;
      tq.delete();
      rsp.delete();
      n = 0;
      while (write_ready_n === 1'b0 && n < 16) begin
         cpu.put(9'h080, itm(n), par(itm(n)));
         cpu.put(9'h180, itm(n + 1), par(itm(n + 1)));
         n += 2;
      end
      chk(n >= 6 && n <= 12, 1'b1);
      cpu.rel();
      chk(write_ready_n, 1'b0);
      cpu.put(9'h000, 64'h5000, 8'h00);
      chk(write_ready_n, 1'b1);
      cpu.rel();
      repeat (4) @(posedge core_clk);
      tgtAccept <= 1'b1;
      do @(posedge core_clk); while (tq.size() < n + 1);
      chk(write_ready_n, 1'b0);
      for (int k = 0; k < n; k++)
         chk(tq[k], {k[0] ? 9'h180 : 9'h080, par(itm(k)), itm(k)});
      chk(tq[n], {9'h000, 8'h00, 64'h5000});
      give(64'h55, 1'b0, 1'b0);
      wrsp(1);
      chk(rsp[0], {9'h100, par(64'h55), 64'h55});
      // Write parity error, enabled then checking disabled
      axw(REG_CTRL, 32'h4, r);
      nPar = 0;
      badwr();
      chk(nPar, 1);
      axw(REG_CTRL, 32'h5, r);
      badwr();
      chk(nPar, 1);
      // Unmatched reads, good then bad parity
      axw(REG_CTRL, 32'h8, r);
      nNt = 0;
      rdq(9'h000, 64'h7000);
      give(64'hDEAD_BEEF, 1'b0, 1'b1);
      wrsp(1);
      chk(rsp[0], {9'h100, 8'h00, 64'h0});
      chk(nNt, 1);
      axw(REG_CTRL, 32'h28, r);
      rdq(9'h000, 64'h7008);
      give(64'hDEAD_BEEF, 1'b0, 1'b1);
      wrsp(1);
      chk({rsp[0][63:0], rsp[0][71:64] !== 8'h00}, {64'h0, 1'b1});
      // Multi-controller: zeros only after the time-out
      axw(REG_TOUT, 32'h4, r);
      chk(r, RESP_OK);
      axr(REG_TOUT, d, r);
      chk({r, d}, {RESP_OK, 32'h4});
      axw(REG_CTRL, 32'h18, r);
      rdq(9'h000, 64'h7010);
      t4 = $realtime;
      give(64'hDEAD_BEEF, 1'b0, 1'b1);
      wrsp(1);
      chk(rsp[0], {9'h100, 8'h00, 64'h0});
      chk(rspT[0] - t4 > 40.0, 1'b1);
      chk(nNt, 3);
      end_sim();
   end
endmodule
